/* ops_pkg.sv */
package ops_pkg;

   // Register map
   localparam logic [7:0] REG_PRESET0 = 8'h00;
   localparam logic [7:0] REG_PRESET1 = 8'h01;
   localparam logic [7:0] REG_PRESET2 = 8'h02;
   localparam logic [7:0] REG_PRESET3 = 8'h03;
   localparam logic [7:0] REG_CTRL = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h05;
   localparam int NUM_RW_REGS = 5;

   // Field positions
   localparam int PRESET_MODE_BIT = 7;
   localparam int CTRL_DISC_BIT = 7;
   localparam int CTRL_SLOPE_LSB = 0;
   localparam int SLOPE_W = 3;
   localparam int STAT_REG_BIT = 7;
   localparam logic [7:0] CTRL_MASK = 8'h87;
   localparam logic [7:0] MODE_MASK = 8'h80;

   // Values after reset
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PRESET0_RESET = 8'h3F;
   localparam logic [7:0] PRESET1_RESET = 8'h17;
   localparam logic [7:0] PRESET2_RESET = 8'h3F;
   localparam logic [7:0] PRESET3_RESET = 8'h21;

   // Voltage code mapping
   localparam int CODE_W_NARROW = 6;
   localparam int BASE_MV_NARROW = 770;
   localparam int MV_PER_CODE = 10;

   // Serial address, value is arbitrary
   localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h4A;

   // Timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int STEP_BASE_PS = 312500;
   localparam int SS_TIME_US = 100;
   localparam int SS_CYC = SS_TIME_US * 1000000 / CLK_PERIOD_PS;

   typedef struct packed {
      logic fpwm;
      logic [6:0] code;
   } ops_preset_t;

   typedef enum logic [2:0] {
      I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_WR, I2C_ACK_W, I2C_RD, I2C_ACK_R
   } ops_i2c_state_t;

   typedef enum logic [1:0] {
      PWR_OFF, PWR_SOFT, PWR_RAMP, PWR_REG
   } ops_pwr_state_t;

endpackage

/* ops_output_preset_select.sv */
`timescale 1ns/1ps
// Summary of operation
// RULE_01: Enable high runs, enable low shuts down
// RULE_02: Enabled stage switches toward selected preset voltage
// RULE_03: Serial registers work regardless of enable level
// RULE_04: Discharge bit plus low enable discharges output
// RULE_05: Discharge bit reads cleared after reset
// RULE_06: Soft start rises first to lowest code
// RULE_07: Then ramps at slope to target, regulates
// RULE_08: Select pins pick preset, high pin MSB
// RULE_09: Presets reset to defaults, power-save mode
// RULE_10: Each preset holds code and mode
// RULE_11: One slope setting serves all presets
// RULE_12: Narrow codes: 770 mV plus 10 mV steps
// RULE_13: Wide codes: 500 mV plus 10 mV steps
// RULE_14: Active preset write applies at transaction end
// RULE_15: Select pin change retargets output at once
// RULE_16: Inactive preset writes leave output untouched
// RULE_17: Host must drive select pins to levels
// RULE_18: Slope code 000 is 32 mV/us, halving
// RULE_19: Bit 7 selects preset mode independently
// RULE_20: Preset is eight bits, code low, mode top
module ops_output_preset_select #(
   parameter int CODE_W = ops_pkg::CODE_W_NARROW,
   parameter int BASE_MV = ops_pkg::BASE_MV_NARROW,
   parameter logic [7:0] PRESET0_RESET = ops_pkg::PRESET0_RESET,
   parameter logic [7:0] PRESET1_RESET = ops_pkg::PRESET1_RESET,
   parameter logic [7:0] PRESET2_RESET = ops_pkg::PRESET2_RESET,
   parameter logic [7:0] PRESET3_RESET = ops_pkg::PRESET3_RESET,
   parameter logic [6:0] I2C_ADDR = ops_pkg::I2C_ADDR_DEFAULT,
   parameter int SS_CYC = ops_pkg::SS_CYC,
   parameter int STEP_BASE_PS = ops_pkg::STEP_BASE_PS
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable_pin,
   input wire logic preset_pick_low,
   input wire logic preset_pick_high,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic switch_en,
   output logic soft_start,
   output logic regulating,
   output logic fpwm,
   output logic discharge_en,
   output logic [6:0] setpoint_code,
   output logic [10:0] setpoint_mv
);

   localparam logic [7:0] CODE_MASK = 8'((16'h1 << CODE_W) - 16'h1);
   localparam logic [7:0] PRESET_MASK = CODE_MASK | ops_pkg::MODE_MASK;
   localparam logic [4:0][7:0] RESET_VALS = {ops_pkg::CTRL_RESET, PRESET3_RESET,
      PRESET2_RESET, PRESET1_RESET, PRESET0_RESET};
   localparam logic [7:0][15:0] STEP_CYC = {
      16'((STEP_BASE_PS << 7) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 6) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 5) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 4) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 3) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 2) / ops_pkg::CLK_PERIOD_PS),
      16'((STEP_BASE_PS << 1) / ops_pkg::CLK_PERIOD_PS),
      16'(STEP_BASE_PS / ops_pkg::CLK_PERIOD_PS)};

   // Pin synchronisers
   logic [4:0] pin_meta_reg;
   logic [4:0] pin_sync_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   wire logic en_s = pin_sync_reg[0];
   wire logic [1:0] sel = pin_sync_reg[2:1];
   wire logic scl_s = pin_sync_reg[3];
   wire logic sda_s = pin_sync_reg[4];

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         // Serial lines rest high, so no false edge follows reset
         pin_meta_reg <= 5'h18;
         pin_sync_reg <= 5'h18;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         pin_meta_reg <= {sda_in, scl_in, preset_pick_high, preset_pick_low, enable_pin};
         pin_sync_reg <= pin_meta_reg;
         scl_prev_reg <= scl_s;
         sda_prev_reg <= sda_s;
      end
   end

   wire logic scl_rise = scl_s & ~scl_prev_reg;
   wire logic scl_fall = ~scl_s & scl_prev_reg;
   wire logic bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
   wire logic bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

   // Register storage: live copy steers the converter, shadow collects writes
   logic [4:0][7:0] live_reg;
   logic [4:0][7:0] shadow_reg;
   ops_pkg::ops_pwr_state_t pwr_reg;
   logic [6:0] sp_reg;

   function automatic logic [7:0] rd_byte(input logic [7:0] idx, input logic [4:0][7:0] regs,
                                          input logic [7:0] stat);
      if (idx <= ops_pkg::REG_PRESET3) begin
         rd_byte = regs[idx[2:0]] & PRESET_MASK;
      end else if (idx == ops_pkg::REG_CTRL) begin
         rd_byte = regs[4] & ops_pkg::CTRL_MASK;
      end else if (idx == ops_pkg::REG_STATUS) begin
         rd_byte = stat;
      end else begin
         rd_byte = 8'h00;
      end
   endfunction

   function automatic logic [7:0] wr_mask(input logic [7:0] idx);
      if (idx <= ops_pkg::REG_PRESET3) begin
         wr_mask = PRESET_MASK; // see RULE_20
      end else begin
         wr_mask = ops_pkg::CTRL_MASK;
      end
   endfunction

   wire logic [7:0] status_byte = {pwr_reg == ops_pkg::PWR_REG, sp_reg};

   // Serial slave
   ops_pkg::ops_i2c_state_t i2c_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic [7:0] tx_reg;
   logic [7:0] ptr_reg;
   logic rw_reg;
   logic first_reg;
   logic ack_ok_reg;
   logic sda_low_reg;
   wire logic [7:0] rd_now = rd_byte(ptr_reg, live_reg, status_byte);
   wire logic byte_end = scl_fall & (bit_cnt_reg == 4'h8);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         i2c_reg <= ops_pkg::I2C_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         tx_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         first_reg <= 1'b0;
         ack_ok_reg <= 1'b0;
         sda_low_reg <= 1'b0;
         shadow_reg <= RESET_VALS; // see RULE_05, see RULE_09
      end else if (bus_start) begin
         i2c_reg <= ops_pkg::I2C_ADDR; // see RULE_03
         bit_cnt_reg <= 4'h0;
         first_reg <= 1'b1;
         sda_low_reg <= 1'b0;
      end else if (bus_stop) begin
         i2c_reg <= ops_pkg::I2C_IDLE;
         sda_low_reg <= 1'b0;
      end else begin
         if (scl_rise && i2c_reg != ops_pkg::I2C_IDLE) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            if (i2c_reg == ops_pkg::I2C_ACK_R) begin
               ack_ok_reg <= ~sda_s;
            end else if (bit_cnt_reg != 4'h8) begin
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
         end
         if (scl_fall) begin
            case (i2c_reg)
               ops_pkg::I2C_ADDR: begin
                  if (byte_end && shift_reg[7:1] == I2C_ADDR) begin
                     rw_reg <= shift_reg[0];
                     sda_low_reg <= 1'b1;
                     i2c_reg <= ops_pkg::I2C_ACK_A;
                  end else if (byte_end) begin
                     i2c_reg <= ops_pkg::I2C_IDLE;
                  end
               end
               ops_pkg::I2C_ACK_A: begin
                  bit_cnt_reg <= 4'h0;
                  if (rw_reg) begin
                     tx_reg <= rd_now;
                     sda_low_reg <= ~rd_now[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     i2c_reg <= ops_pkg::I2C_RD;
                  end else begin
                     sda_low_reg <= 1'b0;
                     i2c_reg <= ops_pkg::I2C_WR;
                  end
               end
               ops_pkg::I2C_WR: begin
                  if (byte_end) begin
                     first_reg <= 1'b0;
                     sda_low_reg <= 1'b1;
                     i2c_reg <= ops_pkg::I2C_ACK_W;
                     if (first_reg) begin
                        ptr_reg <= shift_reg;
                     end else begin
                        ptr_reg <= ptr_reg + 8'h01;
                        if (ptr_reg <= ops_pkg::REG_CTRL) begin
                           shadow_reg[ptr_reg[2:0]] <= shift_reg & wr_mask(ptr_reg); // see RULE_10
                        end
                     end
                  end
               end
               ops_pkg::I2C_ACK_W: begin
                  sda_low_reg <= 1'b0;
                  bit_cnt_reg <= 4'h0;
                  i2c_reg <= ops_pkg::I2C_WR;
               end
               ops_pkg::I2C_RD: begin
                  if (byte_end) begin
                     sda_low_reg <= 1'b0;
                     i2c_reg <= ops_pkg::I2C_ACK_R;
                  end else begin
                     sda_low_reg <= ~tx_reg[6];
                     tx_reg <= {tx_reg[6:0], 1'b0};
                  end
               end
               ops_pkg::I2C_ACK_R: begin
                  bit_cnt_reg <= 4'h0;
                  if (ack_ok_reg) begin
                     tx_reg <= rd_now;
                     sda_low_reg <= ~rd_now[7];
                     ptr_reg <= ptr_reg + 8'h01;
                     i2c_reg <= ops_pkg::I2C_RD;
                  end else begin
                     i2c_reg <= ops_pkg::I2C_IDLE;
                  end
               end
               default: begin
                  sda_low_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe_n = ~sda_low_reg;

   // Writes reach the converter only at a start or stop condition
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         live_reg <= RESET_VALS; // see RULE_05, see RULE_09
      end else if (bus_start || bus_stop) begin
         live_reg <= shadow_reg; // see RULE_14
      end
   end

   // Active preset follows the pins directly
   wire ops_pkg::ops_preset_t act =
      ops_pkg::ops_preset_t'(live_reg[sel]); // see RULE_08, see RULE_15, see RULE_16
   wire logic [6:0] target = act.code & CODE_MASK[6:0];
   wire logic [ops_pkg::SLOPE_W-1:0] slope =
      live_reg[4][ops_pkg::CTRL_SLOPE_LSB +: ops_pkg::SLOPE_W]; // see RULE_11
   wire logic [15:0] step_len = STEP_CYC[slope]; // see RULE_18
   wire logic disc_set = live_reg[4][ops_pkg::CTRL_DISC_BIT];

   // Converter sequencing
   logic [15:0] tmr_reg;
   logic fpwm_reg;
   logic disc_reg;
   logic [10:0] mv_reg;

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pwr_reg <= ops_pkg::PWR_OFF;
         tmr_reg <= 16'h0000;
         sp_reg <= 7'h00;
      end else if (!en_s) begin
         pwr_reg <= ops_pkg::PWR_OFF; // see RULE_01
         sp_reg <= 7'h00;
      end else begin
         case (pwr_reg)
            ops_pkg::PWR_OFF: begin
               pwr_reg <= ops_pkg::PWR_SOFT; // see RULE_01, see RULE_02
               tmr_reg <= 16'(SS_CYC - 1);
            end
            ops_pkg::PWR_SOFT: begin
               if (tmr_reg == 16'h0000) begin
                  pwr_reg <= ops_pkg::PWR_RAMP; // see RULE_06
                  tmr_reg <= step_len - 16'h0001;
               end else begin
                  tmr_reg <= tmr_reg - 16'h0001;
               end
            end
            default: begin
               if (pwr_reg == ops_pkg::PWR_RAMP && sp_reg == target) begin
                  pwr_reg <= ops_pkg::PWR_REG; // see RULE_07
               end
               if (tmr_reg == 16'h0000) begin
                  tmr_reg <= step_len - 16'h0001;
                  if (sp_reg < target) begin
                     sp_reg <= sp_reg + 7'h01; // see RULE_07
                  end else if (sp_reg > target) begin
                     sp_reg <= sp_reg - 7'h01;
                  end
               end else begin
                  tmr_reg <= tmr_reg - 16'h0001;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fpwm_reg <= 1'b0;
         disc_reg <= 1'b0;
         mv_reg <= 11'h000;
      end else begin
         fpwm_reg <= act.fpwm; // see RULE_19
         disc_reg <= ~en_s & disc_set; // see RULE_04
         mv_reg <= 11'(BASE_MV) + 11'(sp_reg * ops_pkg::MV_PER_CODE); // see RULE_12, see RULE_13
      end
   end

   assign switch_en = pwr_reg != ops_pkg::PWR_OFF; // see RULE_02
   assign soft_start = pwr_reg == ops_pkg::PWR_SOFT;
   assign regulating = pwr_reg == ops_pkg::PWR_REG;
   assign fpwm = fpwm_reg;
   assign discharge_en = disc_reg;
   assign setpoint_code = sp_reg;
   assign setpoint_mv = mv_reg;

endmodule // ops_output_preset_select

/* ops_chk.sv */
`timescale 1ns/1ps
module ops_chk #(
   parameter int BASE_MV = 770,
   parameter int SS_CYC = 8
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic enable_pin,
   input wire logic switch_en,
   input wire logic soft_start,
   input wire logic regulating,
   input wire logic discharge_en,
   input wire logic [6:0] setpoint_code,
   input wire logic [10:0] setpoint_mv
);
   int ss_cnt;
   // Length of the current soft-start phase
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ss_cnt <= 0;
      end else begin
         ss_cnt <= soft_start ? ss_cnt + 1 : 0;
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_off_when_low: assert property (!enable_pin [*4] |-> !switch_en)
      else $error("Switching with enable low");
   a_disc_off_run: assert property (enable_pin [*4] |-> !discharge_en)
      else $error("Discharge while enabled");
   a_soft_code_zero: assert property (soft_start |->
      setpoint_code == 7'h00 && switch_en) else $error("Soft start with nonzero setpoint");
   a_soft_len: assert property ($fell(soft_start) && switch_en |->
      ss_cnt >= SS_CYC - 1 && ss_cnt <= SS_CYC + 1) else $error("Soft start length wrong");
   a_switch_soft: assert property ($rose(switch_en) |-> soft_start)
      else $error("Start without soft start");
   a_reg_state: assert property (regulating |-> switch_en && !soft_start)
      else $error("Regulating flag out of state");
   a_step_one: assert property (switch_en && $past(switch_en) |->
      setpoint_code == $past(setpoint_code) || setpoint_code == $past(setpoint_code) + 7'h01
      || setpoint_code == $past(setpoint_code) - 7'h01) else $error("Setpoint jumped");
   a_mv_map: assert property (!$past(rst) |->
      setpoint_mv == 11'(BASE_MV + 10 * $past(setpoint_code))) else $error("Millivolt map wrong");
endmodule // ops_chk
bind ops_output_preset_select ops_chk #(.BASE_MV(BASE_MV), .SS_CYC(SS_CYC)) i_ops_chk (
   .ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin), .switch_en(switch_en),
   .soft_start(soft_start), .regulating(regulating), .discharge_en(discharge_en),
   .setpoint_code(setpoint_code), .setpoint_mv(setpoint_mv)
);

/* ops_host.sv */
`timescale 1ns/1ps
module ops_host #(
   parameter int H = 6
) (
   input wire logic ref_clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic start();
      sda_low = 1'b1;
      tick(H);
      scl = 1'b0;
      tick(H);
   endtask
   task automatic rstart();
      sda_low = 1'b0;
      tick(H);
      scl = 1'b1;
      tick(H);
      start();
   endtask
   task automatic stop();
      sda_low = 1'b1;
      tick(H);
      scl = 1'b1;
      tick(H);
      sda_low = 1'b0;
      tick(H);
   endtask
   // One byte plus acknowledge slot; rel leaves the line to the device
   task automatic xfer(input logic [7:0] b, input logic rel, output logic [7:0] r,
                       output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low = rel ? 1'b0 : !b[i];
         tick(H);
         scl = 1'b1;
         tick(H);
         r[i] = sda;
         scl = 1'b0;
         tick(H);
      end
      sda_low = 1'b0;
      tick(H);
      scl = 1'b1;
      tick(H);
      ack = !sda;
      scl = 1'b0;
      tick(H);
   endtask
endmodule // ops_host

/* test_output_preset_select.sv */
`timescale 1ns/1ps
module test_output_preset_select;
   localparam logic [6:0] ADDR = ops_pkg::I2C_ADDR_DEFAULT;
   localparam logic [7:0] NEW_PRE [4] = '{8'h85, 8'h0A, 8'hFF, 8'h82};
   localparam logic [7:0] RD_PRE [4] = '{8'h85, 8'h0A, 8'hBF, 8'h82};
   localparam logic [7:0] RST_PRE [4] = '{ops_pkg::PRESET0_RESET, ops_pkg::PRESET1_RESET,
      ops_pkg::PRESET2_RESET, ops_pkg::PRESET3_RESET};
   logic ref_clk;
   logic rst;
   logic enable_pin;
   logic pick_low;
   logic pick_high;
   logic scl, sda_low, sda, sda_out, sda_oe_n, switch_en, soft_start, regulating, fpwm;
   logic discharge_en;
   logic [6:0] setpoint_code;
   logic [10:0] setpoint_mv;
   int fail_count = 0;
   int total_checks = 0;
   int cyc = 0;
   // Open-drain line with pull-up
   assign sda = !(sda_low || (!sda_oe_n && !sda_out));
   ops_output_preset_select #(.SS_CYC(8), .STEP_BASE_PS(16000)) i_ops_output_preset_select (
      .ref_clk(ref_clk), .rst(rst), .enable_pin(enable_pin), .preset_pick_low(pick_low),
      .preset_pick_high(pick_high), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe_n(sda_oe_n), .switch_en(switch_en), .soft_start(soft_start),
      .regulating(regulating), .fpwm(fpwm), .discharge_en(discharge_en),
      .setpoint_code(setpoint_code), .setpoint_mv(setpoint_mv)
   );
   ops_host i_ops_host (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(sda_low));
   initial begin
      ref_clk = 1'b0;
      forever begin
         #4;
         ref_clk = ~ref_clk;
      end
   end
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      if (fail_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 40000) begin
         fail_count++;
         wrap_up();
      end
   end
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic a0, a1, a2;
      i_ops_host.start();
      i_ops_host.xfer({ADDR, 1'b0}, 1'b0, r, a0);
      i_ops_host.xfer(idx, 1'b0, r, a1);
      i_ops_host.xfer(d, 1'b0, r, a2);
      i_ops_host.stop();
      chk({8'h00, a0, a1, a2}, 11'h007);
   endtask
   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic a;
      i_ops_host.start();
      i_ops_host.xfer({ADDR, 1'b0}, 1'b0, r, a);
      i_ops_host.xfer(idx, 1'b0, r, a);
      i_ops_host.rstart();
      i_ops_host.xfer({ADDR, 1'b1}, 1'b0, r, a);
      i_ops_host.xfer(8'hFF, 1'b1, r, a);
      i_ops_host.stop();
      chk({3'b000, r}, {3'b000, exp});
   endtask
   task automatic wait_code(input logic [6:0] exp);
      int n;
      n = 0;
      while (setpoint_code !== exp && n < 3000) begin
         i_ops_host.tick(1);
         n++;
      end
      chk({4'h0, setpoint_code}, {4'h0, exp});
   endtask
   initial begin
      logic [7:0] r;
      logic a;
      int t0;
      rst = 1'b1;
      enable_pin = 1'b0;
      pick_low = 1'b0;
      pick_high = 1'b0;
      repeat (4) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      i_ops_host.tick(4);
      chk({10'h000, discharge_en}, 11'h000);
      for (int i = 0; i < 4; i++) begin
         reg_rd(8'(i), RST_PRE[i]);
      end
      reg_rd(8'h04, 8'h00);
      i_ops_host.start();
      i_ops_host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b0, r, a);
      i_ops_host.stop();
      chk({10'h000, a}, 11'h000);
      for (int i = 0; i < 4; i++) begin
         reg_wr(8'(i), NEW_PRE[i]);
         reg_rd(8'(i), RD_PRE[i]);
      end
      reg_wr(8'h04, 8'hFF);
      reg_rd(8'h04, 8'h87);
      reg_wr(8'h04, 8'h80);
      enable_pin = 1'b1;
      for (int j = 0; j < 5; j++) begin
         pick_high = 1'((j % 4) >> 1);
         pick_low = 1'(j % 2);
         wait_code(RD_PRE[j % 4][6:0]);
         i_ops_host.tick(2);
         chk({9'h000, regulating, fpwm}, {9'h001, RD_PRE[j % 4][7]});
         chk(setpoint_mv, 11'(770 + 10 * RD_PRE[j % 4][6:0]));
      end
      reg_wr(8'h01, 8'h20);
      chk({4'h0, setpoint_code}, 11'h005);
      reg_wr(8'h00, 8'h08);
      wait_code(7'h08);
      for (int k = 0; k < 4; k++) begin
         reg_wr(8'h04, 8'h80 | 8'(k));
         reg_wr(8'h00, 8'(16 + 8 * k));
         @(setpoint_code);
         @(setpoint_code);
         t0 = cyc;
         @(setpoint_code);
         chk(11'(cyc - t0), 11'(2 << k));
         wait_code(7'(16 + 8 * k));
      end
      enable_pin = 1'b0;
      i_ops_host.tick(5);
      chk({8'h00, switch_en, discharge_en, |setpoint_code}, 11'h002);
      reg_rd(8'h01, 8'h20);
      rst = 1'b1;
      i_ops_host.tick(4);
      rst = 1'b0;
      i_ops_host.tick(4);
      chk({10'h000, discharge_en}, 11'h000);
      reg_rd(8'h01, RST_PRE[1]);
      reg_rd(8'h04, 8'h00);
      wrap_up();
   end
endmodule // test_output_preset_select
